// file: include/pwr_pkg.sv
package pwr_pkg;
  // Core clock rate and the slow wake oscillator it stands in for
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_NS = 40;
  localparam int SLOW_HZ = 380_000;
  localparam logic [6:0] SLOW_DIV = 7'(CLK_HZ / SLOW_HZ);
  // Boot time is a least time, so it rounds up
  localparam int BOOT_NS = 100_000;
  localparam logic [11:0] BOOT_CYC = 12'((BOOT_NS + CLK_NS - 1) / CLK_NS);
  // Probe burst is a longest time, so it rounds down
  localparam int PROBE_NS = 20_000;
  localparam logic [11:0] PROBE_CYC = 12'(PROBE_NS / CLK_NS);
  // Listening phase length in slow oscillator ticks
  localparam int LISTEN_MS = 500;
  localparam int LISTEN_W = 20;
  localparam logic [19:0] LISTEN_TICKS = 20'(LISTEN_MS * (SLOW_HZ / 1000));
  // Register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_BATT = 4'h4;
  localparam logic [3:0] OFS_LISTEN = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  // Control register fields
  localparam int C_MON = 0;
  localparam int C_STBY = 1;
  localparam int C_LOOP = 2;
  localparam int C_LPP = 3;
  localparam int C_WK_HOST = 4;
  localparam int C_WK_RF = 5;
  localparam int C_WK_TMR = 6;
  localparam int C_OSC = 7;
  localparam int C_TECH = 8;
  localparam int TECH_W = 4;
  localparam int CTRL_W = 12;
  localparam logic [11:0] CTRL_RST = 12'hff0;
  // Battery threshold fields
  localparam int CRIT_LSB = 0;
  localparam int HYST_LSB = 8;
  localparam logic [7:0] CRIT_RST = 8'h40;
  localparam logic [7:0] HYST_RST = 8'h08;
  // Synchronised pin positions
  localparam int P_EN = 0;
  localparam int P_BAT = 1;
  localparam int P_RF = 2;
  // Power state and functional mode codes
  localparam logic [1:0] PWR_MON = 2'h0;
  localparam logic [1:0] PWR_DPD = 2'h1;
  localparam logic [1:0] PWR_STBY = 2'h2;
  localparam logic [1:0] PWR_ACT = 2'h3;
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_LISTEN = 2'h1;
  localparam logic [1:0] MODE_POLL = 2'h2;
  localparam logic [1:0] MODE_NONE = 2'h3;
  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    S_DPD = 7'h01, S_MON = 7'h02, S_BOOT = 7'h04, S_STBY = 7'h08,
    S_IDLE = 7'h10, S_LISTEN = 7'h20, S_POLL = 7'h40
  } state_type;
  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;
  // Status outputs toward the rest of the chip
  typedef struct packed {
    logic [1:0] pwr;
    logic [1:0] mode;
    logic full;
    logic comm;
    logic pmu_on;
    logic cpu_on;
    logic rf_on;
    logic probe;
    logic [3:0] tech;
  } out_type;
  // Pin synchroniser state
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] o;
  } sync_type;
  // Wake timer state
  typedef struct packed {
    logic [6:0] div;
    logic [19:0] cnt;
    logic run;
    logic exp;
  } tmr_type;
  // Sequencer state
  typedef struct packed {
    state_type st;
    logic [11:0] ctrl;
    logic [7:0] crit;
    logic [7:0] hyst;
    logic [19:0] listen;
    logic [11:0] cnt;
    logic full_poll;
    logic [31:0] rdata;
    out_type out;
  } mgr_type;
endpackage : pwr_pkg

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [2:0] pin_i,  // Raw pins
  output logic [2:0] pin_o  // Filtered levels
);
  pwr_pkg::sync_type q;  // Registered state
  pwr_pkg::sync_type n;  // Next state

  // Three stages; output moves only when stages two and three agree
  always_comb begin
    n = q;
    n.s1 = pin_i;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.o = (q.s2 & q.s3) | (q.o & (q.s2 ^ q.s3));
  end

  // State register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign pin_o = q.o;
endmodule : pin_sync

// file: rtl/wake_timer.sv
`timescale 1ns/1ps
module wake_timer (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic osc_en_i,  // Slow oscillator running
  input wire logic start_i,  // Load and run
  input wire logic [19:0] load_i,  // Ticks to count
  output logic run_o,  // Counting
  output logic expire_o  // One-cycle expiry pulse
);
  pwr_pkg::tmr_type q;  // Registered state
  pwr_pkg::tmr_type n;  // Next state
  logic tick;  // Slow oscillator edge

  // Slow tick only while the oscillator is enabled; no ticks means no expiry
  always_comb begin
    n = q;
    n.exp = 1'b0;
    tick = osc_en_i && (q.div == pwr_pkg::SLOW_DIV - 7'h01);
    if (!osc_en_i || tick) begin
      n.div = '0;
    end else begin
      n.div = q.div + 7'h01;
    end
    if (start_i) begin
      n.cnt = load_i;
      n.run = 1'b1;
    end else if (q.run && tick) begin
      // Zero load expires on the first tick
      if (q.cnt <= 20'h00001) begin
        n.run = 1'b0;
        n.exp = 1'b1;
        n.cnt = '0;
      end else begin
        n.cnt = q.cnt - 20'h00001;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign run_o = q.run;
  assign expire_o = q.exp;
endmodule : wake_timer

// file: rtl/nfc_power_state_manager.sv
`timescale 1ns/1ps
// Contract
// R1 - Full power needs battery and enable high
// R2 - No communication while powered off
// R3 - Four power states mapped onto two modes
// R4 - Monitor below critical level, leave with hysteresis
// R5 - Monitor switches internal supply off
// R6 - Only the host enters or leaves deep power down; the code also enters it on battery loss
// R7 - Boot ends in the active state
// R8 - Host should then select standby by default
// R9 - Standby only when the host allows it
// R10 - Standby wakes on host, field or timer
// R11 - Active holds exactly one functional mode
// R12 - Idle keeps RF off, stays without standby
// R13 - Listener turns RF on as card
// R14 - RF done returns to idle or standby
// R15 - Host avoids polling on low battery
// R16 - Loop alternates; each technology has an enable
// R17 - Loop has listening and polling phases
// R18 - Listening stays standby until field appears
// R19 - Low-power polling probes, full loop on target
// R20 - Listening duration is configurable
// R21 - Enable low forces deep power down
// R22 - Enable rise runs boot then idle
module nfc_power_state_manager #(
  parameter logic [19:0] LISTEN_TICKS_DEF = pwr_pkg::LISTEN_TICKS  // Listening ticks at reset
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic power_enable_pin_i,  // Host enable pin
  input wire logic battery_ok_i,  // Battery supply present
  input wire logic rf_field_i,  // RF level detector
  input wire logic [7:0] battery_level_i,  // Battery monitor code, same clock
  input wire logic host_wake_i,  // Host bus address wake pulse
  input wire logic host_idle_i,  // No host traffic pending
  input wire logic target_sensed_i,  // Probe saw a target
  input wire logic rf_done_i,  // RF exchange finished
  input wire pwr_pkg::bus_req_type bus_i,  // Register port request
  output logic [31:0] rdata_o,  // Read data, cycle after read strobe
  output pwr_pkg::out_type status_o  // Power and mode outputs
);
  pwr_pkg::mgr_type q;  // Registered state
  pwr_pkg::mgr_type n;  // Next state
  logic [2:0] pins;  // Synchronised pins
  logic alive;  // Battery and enable both up
  logic mon_low;  // Monitoring on and battery critical
  logic bat_rec;  // Battery back at or above threshold plus hysteresis
  logic tech_any;  // At least one technology in the loop
  logic tmr_start;  // Start listening phase timer
  logic tmr_run;  // Timer counting
  logic tmr_exp;  // Listening phase over

  // Level with hysteresis; widened so the sum cannot wrap
  function automatic logic above_rec(input logic [7:0] lvl, input logic [7:0] crit,
                                     input logic [7:0] hyst);
    return {1'b0, lvl} >= ({1'b0, crit} + {1'b0, hyst});
  endfunction : above_rec

  // Where RF work ends
  function automatic pwr_pkg::state_type back_st(input logic stby);
    return stby ? pwr_pkg::S_STBY : pwr_pkg::S_IDLE;
  endfunction : back_st

  // Power state code of a sequencer state
  function automatic logic [1:0] pwr_of(input pwr_pkg::state_type s);
    case (s)
      pwr_pkg::S_MON: return pwr_pkg::PWR_MON;
      pwr_pkg::S_DPD: return pwr_pkg::PWR_DPD;
      pwr_pkg::S_STBY: return pwr_pkg::PWR_STBY;
      default: return pwr_pkg::PWR_ACT;
    endcase
  endfunction : pwr_of

  // Functional mode code; boot and non-active states have none
  function automatic logic [1:0] mode_of(input pwr_pkg::state_type s);
    case (s)
      pwr_pkg::S_IDLE: return pwr_pkg::MODE_IDLE;
      pwr_pkg::S_LISTEN: return pwr_pkg::MODE_LISTEN;
      pwr_pkg::S_POLL: return pwr_pkg::MODE_POLL;
      default: return pwr_pkg::MODE_NONE;
    endcase
  endfunction : mode_of

  // Pins from outside the clock domain
  pin_sync u_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .pin_i({rf_field_i, battery_ok_i, power_enable_pin_i}),
    .pin_o(pins)
  );

  // Listening phase timer on the slow oscillator
  wake_timer u_tmr (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .osc_en_i(q.ctrl[pwr_pkg::C_OSC]),
    .start_i(tmr_start),
    .load_i(q.listen),
    .run_o(tmr_run),
    .expire_o(tmr_exp)
  );

  // Conditions shared by sequencer and checks
  assign alive = pins[pwr_pkg::P_EN] && pins[pwr_pkg::P_BAT];  // see R1
  assign mon_low = q.ctrl[pwr_pkg::C_MON] && (battery_level_i < q.crit);  // see R4
  assign bat_rec = above_rec(battery_level_i, q.crit, q.hyst);  // see R4
  assign tech_any = |q.ctrl[pwr_pkg::C_TECH +: pwr_pkg::TECH_W];  // see R16
  // Rearm whenever a listening phase is under way and the timer is idle
  assign tmr_start = (q.st == pwr_pkg::S_STBY || q.st == pwr_pkg::S_IDLE) && !tmr_run;  // see R20

  // Register port, sequencer and output decode
  always_comb begin
    n = q;
    n.rdata = '0;
    // Register writes
    if (bus_i.wr) begin
      if (bus_i.addr == pwr_pkg::OFS_CTRL) begin
        n.ctrl = bus_i.wdata[pwr_pkg::CTRL_W-1:0];
      end else if (bus_i.addr == pwr_pkg::OFS_BATT) begin
        n.crit = bus_i.wdata[pwr_pkg::CRIT_LSB +: 8];
        n.hyst = bus_i.wdata[pwr_pkg::HYST_LSB +: 8];
      end else if (bus_i.addr == pwr_pkg::OFS_LISTEN) begin
        n.listen = bus_i.wdata[pwr_pkg::LISTEN_W-1:0];  // see R20
      end
    end
    // Register reads; unmapped reads return zero
    if (bus_i.rd) begin
      if (bus_i.addr == pwr_pkg::OFS_CTRL) begin
        n.rdata = 32'(q.ctrl);
      end else if (bus_i.addr == pwr_pkg::OFS_BATT) begin
        n.rdata = {16'h0000, q.hyst, q.crit};
      end else if (bus_i.addr == pwr_pkg::OFS_LISTEN) begin
        n.rdata = 32'(q.listen);
      end else if (bus_i.addr == pwr_pkg::OFS_STATUS) begin
        n.rdata = 32'({q.out.mode, q.out.pwr, q.st});
      end
    end
    // Enable low wins over everything; the device cannot leave on its own
    if (!alive) begin
      n.st = pwr_pkg::S_DPD;  // see R21, R6
      n.full_poll = 1'b0;
    end else if (mon_low && q.st != pwr_pkg::S_MON) begin
      n.st = pwr_pkg::S_MON;  // see R4
    end else begin
      case (q.st)
        // Enable came up: start boot
        pwr_pkg::S_DPD: begin
          n.st = pwr_pkg::S_BOOT;  // see R22
          n.cnt = '0;
        end
        // Only a recovered battery ends monitoring
        pwr_pkg::S_MON: begin
          if (bat_rec) begin
            n.st = pwr_pkg::S_BOOT;  // see R4
            n.cnt = '0;
          end
        end
        // Boot always lands in active idle
        pwr_pkg::S_BOOT: begin
          if (q.cnt == pwr_pkg::BOOT_CYC - 12'h001) begin
            n.st = pwr_pkg::S_IDLE;  // see R7, R22
          end else begin
            n.cnt = q.cnt + 12'h001;
          end
        end
        // Idle: listening phase when standby is off
        pwr_pkg::S_IDLE: begin
          if (q.ctrl[pwr_pkg::C_LOOP] && pins[pwr_pkg::P_RF]) begin
            n.st = pwr_pkg::S_LISTEN;  // see R18
          end else if (q.ctrl[pwr_pkg::C_LOOP] && tmr_exp && tech_any) begin
            n.st = pwr_pkg::S_POLL;  // see R17, R16
            n.cnt = '0;
            n.full_poll = 1'b0;
          end else if (q.ctrl[pwr_pkg::C_STBY] && host_idle_i) begin
            n.st = pwr_pkg::S_STBY;  // see R9, R12
          end
        end
        // Standby: wait for an enabled wake source
        pwr_pkg::S_STBY: begin
          if (!q.ctrl[pwr_pkg::C_STBY]) begin
            n.st = pwr_pkg::S_IDLE;  // see R9
          end else if (pins[pwr_pkg::P_RF] && q.ctrl[pwr_pkg::C_WK_RF]) begin
            n.st = q.ctrl[pwr_pkg::C_LOOP] ? pwr_pkg::S_LISTEN : pwr_pkg::S_IDLE;  // see R10, R18
          end else if (host_wake_i && q.ctrl[pwr_pkg::C_WK_HOST]) begin
            n.st = pwr_pkg::S_IDLE;  // see R10
          end else if (tmr_exp && q.ctrl[pwr_pkg::C_WK_TMR] && q.ctrl[pwr_pkg::C_OSC]) begin
            if (q.ctrl[pwr_pkg::C_LOOP] && tech_any) begin
              n.st = pwr_pkg::S_POLL;  // see R10, R16, R17
              n.cnt = '0;
              n.full_poll = 1'b0;
            end else begin
              n.st = pwr_pkg::S_IDLE;  // see R10
            end
          end
        end
        // Listener runs until the exchange ends
        pwr_pkg::S_LISTEN: begin
          if (rf_done_i) begin
            n.st = back_st(q.ctrl[pwr_pkg::C_STBY]);  // see R14
          end
        end
        // Poller: short probe first in low-power polling
        pwr_pkg::S_POLL: begin
          if (q.full_poll || !q.ctrl[pwr_pkg::C_LPP]) begin
            if (rf_done_i) begin
              n.st = back_st(q.ctrl[pwr_pkg::C_STBY]);  // see R14
              n.full_poll = 1'b0;
            end
          end else if (target_sensed_i) begin
            n.full_poll = 1'b1;  // see R19
          end else if (q.cnt == pwr_pkg::PROBE_CYC - 12'h001) begin
            n.st = back_st(q.ctrl[pwr_pkg::C_STBY]);  // see R19
          end else begin
            n.cnt = q.cnt + 12'h001;
          end
        end
        default: begin
          n.st = pwr_pkg::S_DPD;
        end
      endcase
    end
    // Outputs follow the next state so they line up with it
    n.out.pwr = pwr_of(n.st);  // see R3
    n.out.mode = mode_of(n.st);  // see R11
    n.out.full = !(n.st inside {pwr_pkg::S_DPD, pwr_pkg::S_MON});  // see R1, R3
    n.out.comm = n.out.full && n.st != pwr_pkg::S_BOOT;  // see R2
    n.out.pmu_on = n.st != pwr_pkg::S_MON;  // see R5
    n.out.cpu_on = n.st inside {pwr_pkg::S_BOOT, pwr_pkg::S_IDLE, pwr_pkg::S_LISTEN,
                                pwr_pkg::S_POLL};  // see R9
    n.out.rf_on = n.st inside {pwr_pkg::S_LISTEN, pwr_pkg::S_POLL};  // see R12, R13, R14
    n.out.probe = n.st == pwr_pkg::S_POLL && n.ctrl[pwr_pkg::C_LPP] && !n.full_poll;  // see R19
    n.out.tech = (n.st == pwr_pkg::S_POLL) ? n.ctrl[pwr_pkg::C_TECH +: pwr_pkg::TECH_W] : '0;
  end

  // State register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
      q.st <= pwr_pkg::S_DPD;
      q.ctrl <= pwr_pkg::CTRL_RST;
      q.crit <= pwr_pkg::CRIT_RST;
      q.hyst <= pwr_pkg::HYST_RST;
      q.listen <= LISTEN_TICKS_DEF;
      q.out.pwr <= pwr_pkg::PWR_DPD;
      q.out.mode <= pwr_pkg::MODE_NONE;
      q.out.pmu_on <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign rdata_o = q.rdata;
  assign status_o = q.out;

  // Enable or battery loss drops into deep power down next cycle
  AST_DPD_ON_LOW: assert property (@(posedge core_clk_i) disable iff (reset_i)  // see R21
    !alive |=> q.st == pwr_pkg::S_DPD && q.out.pwr == pwr_pkg::PWR_DPD)
    else $error("enable low did not force deep power down");

  // Powered-off states never report full power or communication
  AST_OFF_NO_COMM: assert property (@(posedge core_clk_i) disable iff (reset_i)  // see R2
    (q.out.pwr == pwr_pkg::PWR_MON || q.out.pwr == pwr_pkg::PWR_DPD) |-> !q.out.full && !q.out.comm)
    else $error("communication allowed while powered off");

  // Monitor keeps the internal supply off
  AST_PMU_OFF_MON: assert property (@(posedge core_clk_i) disable iff (reset_i)  // see R5
    q.st == pwr_pkg::S_MON |-> !q.out.pmu_on && q.out.pwr == pwr_pkg::PWR_MON)
    else $error("supply on in monitor");

  // Monitor is left for boot only with the battery recovered past hysteresis
  AST_MON_EXIT: assert property (@(posedge core_clk_i) disable iff (reset_i)  // see R4
    $fell(q.st == pwr_pkg::S_MON) && q.st == pwr_pkg::S_BOOT |-> $past(bat_rec))
    else $error("monitor left without recovery");

  // Last boot count lands in idle
  AST_BOOT_IDLE: assert property (@(posedge core_clk_i) disable iff (reset_i)  // see R7
    q.st == pwr_pkg::S_BOOT && q.cnt == pwr_pkg::BOOT_CYC - 12'h001 && alive && !mon_low
    |=> q.st == pwr_pkg::S_IDLE && q.out.mode == pwr_pkg::MODE_IDLE)
    else $error("boot did not end in idle");

  // Standby only with permission
  AST_STBY_CFG: assert property (@(posedge core_clk_i) disable iff (reset_i)  // see R9
    $rose(q.st == pwr_pkg::S_STBY) |-> $past(q.ctrl[pwr_pkg::C_STBY]) && !q.out.cpu_on)
    else $error("standby entered without permission");

  // Active after boot always carries one functional mode
  AST_MODE_ONE: assert property (@(posedge core_clk_i) disable iff (reset_i)  // see R11
    q.out.pwr == pwr_pkg::PWR_ACT && q.st != pwr_pkg::S_BOOT |-> q.out.mode != pwr_pkg::MODE_NONE)
    else $error("active without functional mode");

  // Field in a listening standby goes to listener
  AST_FIELD_LISTEN: assert property (@(posedge core_clk_i) disable iff (reset_i)  // see R18
    q.st == pwr_pkg::S_STBY && q.ctrl[pwr_pkg::C_STBY] && q.ctrl[pwr_pkg::C_LOOP] &&
    q.ctrl[pwr_pkg::C_WK_RF] && pins[pwr_pkg::P_RF] && alive && !mon_low
    |=> q.st == pwr_pkg::S_LISTEN && q.out.rf_on)
    else $error("field did not start listener");

  // End of exchange drops RF and returns to idle or standby
  AST_RF_DONE: assert property (@(posedge core_clk_i) disable iff (reset_i)  // see R14
    q.st == pwr_pkg::S_LISTEN && rf_done_i && alive && !mon_low
    |=> !q.out.rf_on && q.st == $past(back_st(q.ctrl[pwr_pkg::C_STBY])))
    else $error("listener did not return after RF done");

  // A sensed target ends the probe and keeps polling
  AST_PROBE_HIT: assert property (@(posedge core_clk_i) disable iff (reset_i)  // see R19
    q.out.probe && q.st == pwr_pkg::S_POLL && target_sensed_i && alive && !mon_low
    |=> q.st == pwr_pkg::S_POLL && !q.out.probe ##1 q.st == pwr_pkg::S_POLL || !alive || mon_low)
    else $error("target did not start full polling");

  // Polling only starts with a technology enabled
  AST_POLL_TECH: assert property (@(posedge core_clk_i) disable iff (reset_i)  // see R16
    $rose(q.st == pwr_pkg::S_POLL) |-> $past(tech_any) && q.out.tech != '0 || q.ctrl == '0)
    else $error("polling without a technology");
endmodule : nfc_power_state_manager

// file: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic en_req_i,  // Bench asks for enable high
  input wire logic wake_req_i,  // Bench asks for a bus address wake
  input wire logic idle_req_i,  // Bench says no traffic pending
  output logic power_enable_pin_o,
  output logic host_wake_o,
  output logic host_idle_o
);
  // Host pins move just after the edge, like the host's own flops
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      power_enable_pin_o <= 1'b0;  // Device kept off until the host lets go
      host_wake_o <= 1'b0;
      host_idle_o <= 1'b1;
    end else begin
      power_enable_pin_o <= en_req_i;  // Host enable drives power down; battery loss also forces it
      host_wake_o <= wake_req_i;  // Wake is a host bus event only
      host_idle_o <= idle_req_i;
    end
  end
endmodule : host_model

// file: tb/nfc_power_state_manager_test.sv
`timescale 1ns/1ps
module nfc_power_state_manager_test;
  localparam logic [19:0] TICKS = 20'h3;  // Short listening phase keeps the run brief
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic en_cmd = 1'b0;  // Host enable request
  logic wake_cmd = 1'b0;  // Host wake request
  logic idle_cmd = 1'b1;  // Host has nothing to send
  logic battery_ok = 1'b0;
  logic rf_field = 1'b0;
  logic [7:0] level = 8'h80;  // Battery code, well above critical
  logic target = 1'b0;
  logic done = 1'b0;
  pwr_pkg::bus_req_type bus = '0;
  logic power_enable;
  logic host_wake;
  logic host_idle;
  logic [31:0] rdata;
  pwr_pkg::out_type st;
  logic [31:0] exp_q[$];  // Expected read data, oldest first
  logic rd_seen = 1'b0;  // A read was taken at the last edge
  int mismatches = 0;
  int total_checks = 0;
  int seed = 63;
  // Free running core clock
  always #20 core_clk_i = ~core_clk_i;
  host_model HOST (.core_clk_i(core_clk_i), .reset_i(reset_i), .en_req_i(en_cmd),
    .wake_req_i(wake_cmd), .idle_req_i(idle_cmd), .power_enable_pin_o(power_enable),
    .host_wake_o(host_wake), .host_idle_o(host_idle));
  nfc_power_state_manager #(.LISTEN_TICKS_DEF(TICKS)) DUT (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .power_enable_pin_i(power_enable), .battery_ok_i(battery_ok),
    .rf_field_i(rf_field), .battery_level_i(level), .host_wake_i(host_wake),
    .host_idle_i(host_idle), .target_sensed_i(target), .rf_done_i(done), .bus_i(bus),
    .rdata_o(rdata), .status_o(st));
  // Single comparison point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // One strobe cycle, then the port goes quiet
  task automatic bus_op(input logic [3:0] a, input logic [31:0] d, input logic w);
    @(posedge core_clk_i);
    bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge core_clk_i);
    bus <= '0;
  endtask : bus_op
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus_op(a, 32'h0, 1'b0);
  endtask : rd_reg
  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk_i) begin
    if (rd_seen) begin
      check(rdata, exp_q.pop_front());
    end
    rd_seen <= bus.rd;
  end
  // Bounded wait for a power state and mode pair
  task automatic wait_mode(input logic [1:0] p, input logic [1:0] m);
    int n;
    n = 0;
    while (!(st.pwr === p && st.mode === m) && n < 4000) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 4000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : wait_mode
  // Supply flags packed as full, comm, pmu, cpu, rf
  function automatic logic [31:0] flags();
    return 32'({st.full, st.comm, st.pmu_on, st.cpu_on, st.rf_on});
  endfunction : flags
  task automatic pulse(ref logic s);
    @(posedge core_clk_i);
    s <= 1'b1;
    @(posedge core_clk_i);
    s <= 1'b0;
  endtask : pulse
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    wait_mode(pwr_pkg::PWR_DPD, pwr_pkg::MODE_NONE);
    check(flags(), 32'h04);
    rd_reg(pwr_pkg::OFS_CTRL, 32'h0000_0ff0);
    rd_reg(pwr_pkg::OFS_BATT, 32'h0000_0840);
    rd_reg(pwr_pkg::OFS_LISTEN, 32'(TICKS));
    rd_reg(4'h2, 32'h0);
    @(posedge core_clk_i);
    battery_ok <= 1'b1;
    en_cmd <= 1'b1;
    wait_mode(pwr_pkg::PWR_ACT, pwr_pkg::MODE_IDLE);
    check(flags(), 32'h1e);
    rd_reg(pwr_pkg::OFS_STATUS, 32'h0000_0190);
    // Host picks standby after boot
    bus_op(pwr_pkg::OFS_CTRL, 32'h0000_0ff2, 1'b1);
    wait_mode(pwr_pkg::PWR_STBY, pwr_pkg::MODE_NONE);
    check(32'(st.cpu_on), 32'h0);
    @(posedge core_clk_i);
    idle_cmd <= 1'b0;
    pulse(wake_cmd);
    wait_mode(pwr_pkg::PWR_ACT, pwr_pkg::MODE_IDLE);
    check(flags(), 32'h1e);
    // Loop on, standby off: field brings listener
    bus_op(pwr_pkg::OFS_CTRL, 32'h0000_0ff4, 1'b1);
    @(posedge core_clk_i);
    rf_field <= 1'b1;
    wait_mode(pwr_pkg::PWR_ACT, pwr_pkg::MODE_LISTEN);
    check(flags(), 32'h1f);
    @(posedge core_clk_i);
    rf_field <= 1'b0;
    pulse(done);
    wait_mode(pwr_pkg::PWR_ACT, pwr_pkg::MODE_IDLE);
    check(32'(st.rf_on), 32'h0);
    // Loop with standby and low-power probe; battery high for polling
    bus_op(pwr_pkg::OFS_CTRL, 32'h0000_0ffe, 1'b1);
    @(posedge core_clk_i);
    idle_cmd <= 1'b1;
    wait_mode(pwr_pkg::PWR_STBY, pwr_pkg::MODE_NONE);
    check(32'(st.rf_on), 32'h0);
    wait_mode(pwr_pkg::PWR_ACT, pwr_pkg::MODE_POLL);
    check({st.probe, st.rf_on, st.tech}, 6'h3f);
    pulse(target);
    repeat (3) @(negedge core_clk_i);
    check(32'(st.probe), 32'h0);
    pulse(done);
    wait_mode(pwr_pkg::PWR_STBY, pwr_pkg::MODE_NONE);
    check(32'(st.tech), 32'h0);
    // Monitor entry and hysteresis on exit
    bus_op(pwr_pkg::OFS_CTRL, 32'h0000_0ff1, 1'b1);
    wait_mode(pwr_pkg::PWR_ACT, pwr_pkg::MODE_IDLE);
    @(posedge core_clk_i);
    level <= 8'($random(seed)) & 8'h3f;
    wait_mode(pwr_pkg::PWR_MON, pwr_pkg::MODE_NONE);
    check(flags(), 32'h00);
    @(posedge core_clk_i);
    level <= 8'h47;
    repeat (100) @(negedge core_clk_i);
    check(32'(st.pwr), 32'(pwr_pkg::PWR_MON));
    @(posedge core_clk_i);
    level <= 8'h48 + (8'($random(seed)) & 8'h3f);
    wait_mode(pwr_pkg::PWR_ACT, pwr_pkg::MODE_IDLE);
    check(32'(st.pmu_on), 32'h1);
    @(posedge core_clk_i);
    en_cmd <= 1'b0;
    wait_mode(pwr_pkg::PWR_DPD, pwr_pkg::MODE_NONE);
    check(flags(), 32'h04);
    tally_and_finish();
  end
endmodule : nfc_power_state_manager_test
